// File: tdc_dma.sv
// two channel dma controller core: registers, arbitration, transfer sequencing and buffered data path
// Behaviour
// - memory addresses are 19 bits wide and wrap freely across 64k boundaries
// - i/o addresses are driven as 16-bit values
// - each byte moved lowers the 16-bit count by one; zero ends the transfer
// - request input may be level or edge sensed per channel
// - an end-of-transfer output tells external devices a transfer completed
// - one byte every six clocks in channel 0 burst without waits; wait input stretches cycles
// - channel 0 wins when both channels request together
// - channel 0 does mem-mem, mem-io, mapped io; inc/dec/fixed; burst or steal
// - channel 1 moves between memory and i/o either way with two address registers
// - a channel runs only while its enable and the master enable are set
// - channel 1 enable clears itself when its count reaches zero
// - channel 0 enable clears itself when its count reaches zero
// - interrupt request per channel when enable is 0 and interrupt enable is 1
// - channel enable changes on write only when its guard bit is written 0
// - guarded write of 1 to a channel enable also sets master enable
// - guarded write of 0 halts a channel keeping address and count
// - non-maskable interrupt clears master enable
// - master enable is read-only, cleared by nmi or reset, set by enabling
// - status bits: 7 ch1 en, 6 ch0 en, 5/4 guards, 3/2 ie, 0 master
// - reset clears both enables, both interrupt enables and master enable
// - sense bit 0 means level, 1 means edge
// - cycle steal gives the processor one machine cycle between bytes
// - channel 0 starts its first transfer one machine cycle after enabling
`timescale 1ns/10ps
`default_nettype none
module tdc_dma
    import tdc_pkg::*;
#(
    parameter int WAIT_MAX = 3
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic nmi,
    input wire logic [1:0] transfer_request_in_n,
    input wire logic bus_wait,
    output logic bus_valid,
    input wire logic bus_ready,
    output logic bus_write,
    output logic bus_io,
    output logic [18:0] bus_addr,
    output logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    output logic transfer_end_out_n,
    output logic [1:0] dma_irq,
    output logic dma_busy
);
    typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_READ, ST_WRITE, ST_GAP} tdc_state_e;

    logic [18:0] ch0_source_address_q, ch0_destination_address_q, ch1_memory_address_q;
    logic [15:0] ch1_io_address_q, ch0_byte_count_q, ch1_byte_count_q;
    logic ch0_enable_q, ch1_enable_q, ch0_done_irq_enable_q, ch1_done_irq_enable_q;
    logic dma_master_enable_q;
    logic [7:0] ch0_transfer_mode_reg_q, dma_wait_control_reg_q;
    tdc_state_e state_q;
    logic chan_q;
    logic [2:0] phase_q;
    logic [7:0] buf_data_q [2];
    logic [1:0] buf_cnt_q;
    logic buf_wp_q, buf_rp_q;
    logic [2:0] req_s1_q, req_s2_q, req_s3_q;
    logic [1:0] req_lvl_q, req_prev_q, req_edge_q;
    logic last_q;

    // step a memory address by mode
    function automatic logic [18:0] step_addr(input logic [18:0] a, input logic [1:0] m);
        logic [18:0] r;
        r = a;
        unique case (m)
            AM_INC: r = a + 19'h00001;
            AM_DEC: r = a - 19'h00001;
            default: r = a;
        endcase
        return r;
    endfunction

    logic [1:0] dst_mode, src_mode, ch1_mode;
    logic ch0_memmem, ch0_burst;
    assign dst_mode = ch0_transfer_mode_reg_q[5:4];
    assign src_mode = ch0_transfer_mode_reg_q[3:2];
    assign ch1_mode = dma_wait_control_reg_q[1:0];
    assign ch0_memmem = (dst_mode != AM_IO) && (src_mode != AM_IO);
    assign ch0_burst = ch0_transfer_mode_reg_q[B_MEM_TIMING_SELECT];

    logic guard0_ok, guard1_ok, stat_wr;
    assign stat_wr = reg_wr && (reg_addr == STAT_ADDR);
    assign guard0_ok = stat_wr && !reg_wdata[B_CH0_GUARD];
    assign guard1_ok = stat_wr && !reg_wdata[B_CH1_GUARD];

    // request synchroniser: a change counts when second and third stage agree
    always_ff @(posedge core_clk) begin
        if (reset) begin
            req_s1_q <= 3'h0;
            req_s2_q <= 3'h0;
            req_s3_q <= 3'h0;
            req_lvl_q <= 2'h0;
            req_prev_q <= 2'h0;
        end else begin
            req_s1_q <= {1'b0, ~transfer_request_in_n};
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            for (int i = 0; i < 2; i++) begin
                if (req_s2_q[i] == req_s3_q[i]) begin
                    req_lvl_q[i] <= req_s3_q[i];
                end
            end
            req_prev_q <= req_lvl_q;
        end
    end

    logic [1:0] sense, edge_take;
    assign sense = {dma_wait_control_reg_q[B_CH1_SENSE], dma_wait_control_reg_q[B_CH0_SENSE]};

    // latched edge requests; a new edge wins over the consume in the same cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            req_edge_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (req_lvl_q[i] && !req_prev_q[i]) begin
                    req_edge_q[i] <= 1'b1;
                end else if (edge_take[i]) begin
                    req_edge_q[i] <= 1'b0;
                end
            end
        end
    end

    logic [1:0] run, want;
    assign run[0] = ch0_enable_q && dma_master_enable_q && (ch0_byte_count_q != 16'h0000);
    assign run[1] = ch1_enable_q && dma_master_enable_q && (ch1_byte_count_q != 16'h0000);
    assign want[0] = run[0] && (ch0_memmem || (sense[0] ? req_edge_q[0] : req_lvl_q[0]));
    assign want[1] = run[1] && (sense[1] ? req_edge_q[1] : req_lvl_q[1]);

    logic start, pick;
    logic [1:0] wait_cnt_q;
    logic buf_in_ready, buf_out_valid, byte_done, cyc_done;
    assign pick = want[0] ? 1'b0 : 1'b1;
    assign start = (state_q == ST_IDLE) && (want != 2'h0);
    assign edge_take = start ? (pick ? 2'b10 : 2'b01) & sense : 2'h0;

    // a cycle completes after three clocks plus waits and the far side's ready
    assign cyc_done = (phase_q == 3'(MCYCLE_CLOCKS - 1)) && !bus_wait && bus_ready;
    assign byte_done = (state_q == ST_WRITE) && cyc_done;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            chan_q <= 1'b0;
            phase_q <= 3'h0;
            last_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    phase_q <= 3'h0;
                    if (start) begin
                        chan_q <= pick;
                        last_q <= pick ? (ch1_byte_count_q == 16'h0001) : (ch0_byte_count_q == 16'h0001);
                        state_q <= ST_READ;
                    end
                end
                ST_DELAY: begin
                    phase_q <= phase_q + 3'h1;
                    if (phase_q == 3'(MCYCLE_CLOCKS - 1)) begin
                        phase_q <= 3'h0;
                        state_q <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    if (!run[chan_q]) begin
                        state_q <= ST_IDLE;
                    end else if (cyc_done && buf_in_ready) begin
                        phase_q <= 3'h0;
                        state_q <= ST_WRITE;
                    end else if (phase_q != 3'(MCYCLE_CLOCKS - 1)) begin
                        phase_q <= phase_q + 3'h1;
                    end
                end
                ST_WRITE: begin
                    if (byte_done) begin
                        phase_q <= 3'h0;
                        last_q <= (ch0_byte_count_q == 16'h0002);
                        if (!chan_q && ch0_memmem && !last_q && run[0]) begin
                            state_q <= ch0_burst ? ST_READ : ST_GAP;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end else if (phase_q != 3'(MCYCLE_CLOCKS - 1) && buf_out_valid) begin
                        phase_q <= phase_q + 3'h1;
                    end
                end
                ST_GAP: begin
                    phase_q <= phase_q + 3'h1;
                    if (phase_q == 3'(MCYCLE_CLOCKS - 1)) begin
                        phase_q <= 3'h0;
                        state_q <= ST_IDLE;
                    end
                end
            endcase
            if (guard0_ok && reg_wdata[B_CH0_EN] && state_q == ST_IDLE) begin
                phase_q <= 3'h0;
                state_q <= ST_DELAY;
            end
        end
    end

    // two entry buffer between read and write cycles
    logic buf_push, buf_pop;
    assign buf_in_ready = (buf_cnt_q != 2'h2);
    assign buf_out_valid = (buf_cnt_q != 2'h0);
    assign buf_push = (state_q == ST_READ) && cyc_done && buf_in_ready && run[chan_q];
    assign buf_pop = byte_done;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            buf_cnt_q <= 2'h0;
            buf_wp_q <= 1'b0;
            buf_rp_q <= 1'b0;
            buf_data_q[0] <= 8'h00;
            buf_data_q[1] <= 8'h00;
        end else begin
            if (buf_push) begin
                buf_data_q[buf_wp_q] <= bus_rdata;
                buf_wp_q <= ~buf_wp_q;
            end
            if (buf_pop) begin
                buf_rp_q <= ~buf_rp_q;
            end
            buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    // bus drive, loaded for the cycle that starts at this edge so it stands from its first clock
    logic rd_io, wr_io, sel_ch, nxt_write;
    logic [18:0] src_now;
    assign sel_ch = (state_q == ST_IDLE) ? pick : chan_q;
    assign nxt_write = (state_q == ST_WRITE) ? !byte_done : buf_push;
    assign src_now = (state_q == ST_WRITE) ? step_addr(ch0_source_address_q, src_mode) : ch0_source_address_q;
    assign rd_io = sel_ch ? ch1_mode[1] : (src_mode == AM_IO);
    assign wr_io = sel_ch ? !ch1_mode[1] : (dst_mode == AM_IO);
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bus_addr <= 19'h00000;
            bus_io <= 1'b0;
            bus_write <= 1'b0;
            bus_wdata <= 8'h00;
        end else begin
            bus_write <= nxt_write;
            bus_wdata <= (buf_push && !buf_out_valid) ? bus_rdata : buf_data_q[buf_rp_q];
            if (!nxt_write) begin
                bus_io <= rd_io;
                bus_addr <= sel_ch ? (rd_io ? {3'h0, ch1_io_address_q} : ch1_memory_address_q)
                                   : (rd_io ? {3'h0, src_now[15:0]} : src_now);
            end else begin
                bus_io <= wr_io;
                bus_addr <= sel_ch ? (wr_io ? {3'h0, ch1_io_address_q} : ch1_memory_address_q)
                                   : (wr_io ? {3'h0, ch0_destination_address_q[15:0]} : ch0_destination_address_q);
            end
        end
    end
    assign bus_valid = (state_q == ST_READ || state_q == ST_WRITE) && (state_q == ST_READ || buf_out_valid);
    assign dma_busy = (state_q != ST_IDLE);
    assign transfer_end_out_n = !(dma_busy && last_q && (state_q == ST_WRITE));

    // address and count registers with byte writes and per-byte stepping
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ch0_source_address_q <= 19'h00000;
            ch0_destination_address_q <= 19'h00000;
            ch1_memory_address_q <= 19'h00000;
            ch1_io_address_q <= 16'h0000;
            ch0_byte_count_q <= 16'h0000;
            ch1_byte_count_q <= 16'h0000;
        end else begin
            if (byte_done && !chan_q) begin
                ch0_source_address_q <= step_addr(ch0_source_address_q, src_mode);
                ch0_destination_address_q <= step_addr(ch0_destination_address_q, dst_mode);
                ch0_byte_count_q <= ch0_byte_count_q - 16'h0001;
            end
            if (byte_done && chan_q) begin
                ch1_memory_address_q <= step_addr(ch1_memory_address_q, {1'b0, ch1_mode[0]});
                ch1_byte_count_q <= ch1_byte_count_q - 16'h0001;
            end
            if (reg_wr) begin
                unique case (reg_addr)
                    SRC0_LO: ch0_source_address_q[7:0] <= reg_wdata;
                    SRC0_LO + 8'h01: ch0_source_address_q[15:8] <= reg_wdata;
                    SRC0_LO + 8'h02: ch0_source_address_q[18:16] <= reg_wdata[2:0];
                    DST0_LO: ch0_destination_address_q[7:0] <= reg_wdata;
                    DST0_LO + 8'h01: ch0_destination_address_q[15:8] <= reg_wdata;
                    DST0_LO + 8'h02: ch0_destination_address_q[18:16] <= reg_wdata[2:0];
                    CNT0_LO: ch0_byte_count_q[7:0] <= reg_wdata;
                    CNT0_LO + 8'h01: ch0_byte_count_q[15:8] <= reg_wdata;
                    MEM1_LO: ch1_memory_address_q[7:0] <= reg_wdata;
                    MEM1_LO + 8'h01: ch1_memory_address_q[15:8] <= reg_wdata;
                    MEM1_LO + 8'h02: ch1_memory_address_q[18:16] <= reg_wdata[2:0];
                    IO1_LO: ch1_io_address_q[7:0] <= reg_wdata;
                    IO1_LO + 8'h01: ch1_io_address_q[15:8] <= reg_wdata;
                    CNT1_LO: ch1_byte_count_q[7:0] <= reg_wdata;
                    CNT1_LO + 8'h01: ch1_byte_count_q[15:8] <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // enables: hardware clear at count zero, guarded software writes, master enable
    logic ch0_end, ch1_end;
    assign ch0_end = byte_done && !chan_q && last_q;
    assign ch1_end = byte_done && chan_q && last_q;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ch0_enable_q <= 1'b0;
            ch1_enable_q <= 1'b0;
            dma_master_enable_q <= 1'b0;
        end else begin
            if (guard0_ok) begin
                ch0_enable_q <= reg_wdata[B_CH0_EN];
            end else if (ch0_end) begin
                ch0_enable_q <= 1'b0;
            end
            if (guard1_ok) begin
                ch1_enable_q <= reg_wdata[B_CH1_EN];
            end else if (ch1_end) begin
                ch1_enable_q <= 1'b0;
            end
            if (nmi) begin
                dma_master_enable_q <= 1'b0;
            end else if ((guard0_ok && reg_wdata[B_CH0_EN]) || (guard1_ok && reg_wdata[B_CH1_EN])) begin
                dma_master_enable_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ch0_done_irq_enable_q <= 1'b0;
            ch1_done_irq_enable_q <= 1'b0;
            ch0_transfer_mode_reg_q <= MODE_RESET;
            dma_wait_control_reg_q <= CNTL_RESET;
        end else if (reg_wr) begin
            if (reg_addr == STAT_ADDR) begin
                ch0_done_irq_enable_q <= reg_wdata[B_CH0_IE];
                ch1_done_irq_enable_q <= reg_wdata[B_CH1_IE];
            end
            if (reg_addr == MODE_ADDR) begin
                ch0_transfer_mode_reg_q <= {2'h0, reg_wdata[5:1], 1'b0};
            end
            if (reg_addr == CNTL_ADDR) begin
                dma_wait_control_reg_q <= reg_wdata;
            end
        end
    end

    assign dma_irq[0] = !ch0_enable_q && ch0_done_irq_enable_q;
    assign dma_irq[1] = !ch1_enable_q && ch1_done_irq_enable_q;

    // register readback
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                SRC0_LO: reg_rdata <= ch0_source_address_q[7:0];
                SRC0_LO + 8'h01: reg_rdata <= ch0_source_address_q[15:8];
                SRC0_LO + 8'h02: reg_rdata <= {5'h00, ch0_source_address_q[18:16]};
                DST0_LO: reg_rdata <= ch0_destination_address_q[7:0];
                DST0_LO + 8'h01: reg_rdata <= ch0_destination_address_q[15:8];
                DST0_LO + 8'h02: reg_rdata <= {5'h00, ch0_destination_address_q[18:16]};
                CNT0_LO: reg_rdata <= ch0_byte_count_q[7:0];
                CNT0_LO + 8'h01: reg_rdata <= ch0_byte_count_q[15:8];
                MEM1_LO: reg_rdata <= ch1_memory_address_q[7:0];
                MEM1_LO + 8'h01: reg_rdata <= ch1_memory_address_q[15:8];
                MEM1_LO + 8'h02: reg_rdata <= {5'h00, ch1_memory_address_q[18:16]};
                IO1_LO: reg_rdata <= ch1_io_address_q[7:0];
                IO1_LO + 8'h01: reg_rdata <= ch1_io_address_q[15:8];
                CNT1_LO: reg_rdata <= ch1_byte_count_q[7:0];
                CNT1_LO + 8'h01: reg_rdata <= ch1_byte_count_q[15:8];
                STAT_ADDR: reg_rdata <= {ch1_enable_q, ch0_enable_q, 2'b11, ch1_done_irq_enable_q,
                                         ch0_done_irq_enable_q, 1'b0, dma_master_enable_q};
                MODE_ADDR: reg_rdata <= ch0_transfer_mode_reg_q;
                CNTL_ADDR: reg_rdata <= dma_wait_control_reg_q;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: tdc_pkg.sv
// package of register map, field positions and timing constants for the two channel dma controller
package tdc_pkg;
    localparam logic [7:0] SRC0_LO = 8'h20;
    localparam logic [7:0] DST0_LO = 8'h23;
    localparam logic [7:0] CNT0_LO = 8'h26;
    localparam logic [7:0] MEM1_LO = 8'h28;
    localparam logic [7:0] IO1_LO = 8'h2B;
    localparam logic [7:0] CNT1_LO = 8'h2E;
    localparam logic [7:0] STAT_ADDR = 8'h30;
    localparam logic [7:0] MODE_ADDR = 8'h31;
    localparam logic [7:0] CNTL_ADDR = 8'h32;
    localparam int B_CH1_EN = 7;
    localparam int B_CH0_EN = 6;
    localparam int B_CH1_GUARD = 5;
    localparam int B_CH0_GUARD = 4;
    localparam int B_CH1_IE = 3;
    localparam int B_CH0_IE = 2;
    localparam int B_MASTER = 0;
    localparam int B_MEM_TIMING_SELECT = 1;
    localparam int B_CH0_SENSE = 3;
    localparam int B_CH1_SENSE = 2;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CNTL_RESET = 8'hF0;
    localparam int XFER_CLOCKS = 6;
    localparam int MCYCLE_CLOCKS = 3;
    localparam logic [1:0] AM_INC = 2'h0;
    localparam logic [1:0] AM_DEC = 2'h1;
    localparam logic [1:0] AM_FIX = 2'h2;
    localparam logic [1:0] AM_IO = 2'h3;
endpackage

// File: tdc_dma_assertions.sv
// port checker for the two channel dma controller, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module tdc_dma_assertions
    import tdc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic nmi,
    input wire logic bus_wait,
    input wire logic bus_valid,
    input wire logic bus_write,
    input wire logic [18:0] bus_addr,
    input wire logic transfer_end_out_n,
    input wire logic [1:0] dma_irq
);
    logic [1:0] ie_q;
    logic stat_wr;
    assign stat_wr = reg_wr && reg_addr == STAT_ADDR;
    // shadow of the interrupt enables, taken from status writes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ie_q <= 2'h0;
        end else if (stat_wr) begin
            ie_q <= reg_wdata[3:2];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_end_in_write;
        !transfer_end_out_n |-> bus_valid && bus_write;
    endproperty
    a_end_in_write: assert property (p_end_in_write) else $error("end low outside write");
    property p_read_len;
        $rose(bus_valid) |-> bus_valid [*3];
    endproperty
    a_read_len: assert property (p_read_len) else $error("bus cycle too short");
    property p_wait_hold;
        bus_valid && bus_wait |=> bus_valid && $stable(bus_addr);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait did not hold cycle");
    property p_irq_ie;
        (dma_irq & ~ie_q) == 2'h0;
    endproperty
    a_irq_ie: assert property (p_irq_ie) else $error("irq without its enable");
    property p_enable_irq;
        stat_wr && !reg_wdata[4] && reg_wdata[6] |=> !dma_irq[0];
    endproperty
    a_enable_irq: assert property (p_enable_irq) else $error("irq after enable");
    property p_disable_irq;
        stat_wr && !reg_wdata[4] && !reg_wdata[6] && reg_wdata[2] |=> dma_irq[0];
    endproperty
    a_disable_irq: assert property (p_disable_irq) else $error("no irq after halt");
    property p_guard_read;
        reg_rd && reg_addr == STAT_ADDR |=> reg_rdata[5:4] == 2'h3 && !reg_rdata[1];
    endproperty
    a_guard_read: assert property (p_guard_read) else $error("guard bits misread");
    property p_nmi_master;
        nmi [*2] ##0 (reg_rd && reg_addr == STAT_ADDR) |=> !reg_rdata[0];
    endproperty
    a_nmi_master: assert property (p_nmi_master) else $error("master set under nmi");
endmodule
bind tdc_dma tdc_dma_assertions u_tdc_dma_assertions (.core_clk, .reset, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .nmi, .bus_wait, .bus_valid, .bus_write, .bus_addr, .transfer_end_out_n, .dma_irq);
`default_nettype wire

// File: tdc_mem_model.sv
// memory and i/o model on the far side of the dma bus, logging completed writes
`timescale 1ns/10ps
`default_nettype none
module tdc_mem_model (
    input wire logic core_clk,
    input wire logic slow,
    input wire logic bus_valid,
    output logic bus_ready,
    input wire logic bus_write,
    input wire logic bus_io,
    input wire logic [18:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic transfer_end_out_n
);
    logic [19:0] wr_a[$];
    logic [7:0] wr_d[$];
    int ends = 0;
    logic tick_q = 1'b0;
    logic in_wr_q = 1'b0;
    logic end_q = 1'b1;
    logic [19:0] a_q = 20'h00000;
    logic [7:0] d_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    function automatic logic [7:0] pat(input logic [18:0] a);
        return a[7:0] ^ {5'h00, a[18:16]} ^ 8'hA5;
    endfunction
    assign bus_ready = !slow || tick_q;
    // outside a read the data lines change every cycle so no stale byte is mistaken for data
    assign bus_rdata = (bus_valid && !bus_write) ? pat(bus_addr) : ~last_q;
    always @(posedge core_clk) begin
        tick_q <= !tick_q;
        last_q <= bus_rdata;
        end_q <= transfer_end_out_n;
        in_wr_q <= bus_valid && bus_write;
        if (bus_valid && bus_write) begin
            a_q <= {bus_io, bus_addr};
            d_q <= bus_wdata;
        end
        if (in_wr_q && !(bus_valid && bus_write)) begin
            wr_a.push_back(a_q);
            wr_d.push_back(d_q);
        end
        if (end_q && !transfer_end_out_n) ends <= ends + 1;
    end
endmodule
`default_nettype wire

// File: tdc_dma_test.sv
// self-checking testbench for the two channel dma controller
`timescale 1ns/10ps
`default_nettype none
module tdc_dma_test
    import tdc_pkg::*;
;
    logic core_clk, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, nmi = 1'b0, bus_wait = 1'b0, slow = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, bus_wdata, bus_rdata;
    logic [1:0] transfer_request_in_n = 2'h3, dma_irq;
    logic bus_valid, bus_ready, bus_write, bus_io, transfer_end_out_n, dma_busy;
    logic [18:0] bus_addr;
    int failures = 0;
    int checks_done = 0;
    tdc_dma u_tdc_dma (.core_clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .nmi,
        .transfer_request_in_n, .bus_wait, .bus_valid, .bus_ready, .bus_write, .bus_io, .bus_addr,
        .bus_wdata, .bus_rdata, .transfer_end_out_n, .dma_irq, .dma_busy);
    tdc_mem_model u_tdc_mem_model (.core_clk, .slow, .bus_valid, .bus_ready, .bus_write, .bus_io,
        .bus_addr, .bus_wdata, .bus_rdata, .transfer_end_out_n);
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic wrap_up();
        if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #2 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #2 reg_wr = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        #2 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk);
        #2 reg_rd = 1'b0;
        chk(reg_rdata, exp);
    endtask
    task automatic wr19(input logic [7:0] a, input logic [18:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
        wr(a + 8'h02, {5'h00, v[18:16]});
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask
    task automatic wait_log(input int n);
        for (int i = 0; i < 3000 && u_tdc_mem_model.wr_a.size() < n; i++) @(posedge core_clk);
        #2 chk(u_tdc_mem_model.wr_a.size(), n);
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        #2 reset = 1'b0;
        rdchk(STAT_ADDR, 8'h30);
        chk(dma_irq, 2'h0);
        // channel 0 burst copy of three bytes across a 64k boundary
        wr19(SRC0_LO, 19'h0FFFF);
        wr19(DST0_LO, 19'h2FFFE);
        wr16(CNT0_LO, 16'h0003);
        wr(MODE_ADDR, 8'h02);
        wr(STAT_ADDR, 8'h24);
        chk(dma_irq, 2'h1);
        wr(STAT_ADDR, 8'h64);
        wait_log(3);
        repeat (12) @(posedge core_clk);
        for (int i = 0; i < 3; i++) begin
            chk(u_tdc_mem_model.wr_a[i], {1'b0, 19'h2FFFE + 19'(i)});
            chk(u_tdc_mem_model.wr_d[i], u_tdc_mem_model.pat(19'h0FFFF + 19'(i)));
        end
        rdchk(STAT_ADDR, 8'h35);
        rdchk(CNT0_LO, 8'h00);
        rdchk(CNT0_LO + 8'h01, 8'h00);
        chk(u_tdc_mem_model.ends, 1);
        wr(STAT_ADDR, 8'h54);
        repeat (20) @(posedge core_clk);
        rdchk(STAT_ADDR, 8'h35);
        chk(u_tdc_mem_model.wr_a.size(), 3);
        // channel 1 memory to i/o, held off by missing request and by nmi
        wr19(MEM1_LO, 19'h7FFFF);
        wr16(IO1_LO, 16'hABCD);
        wr16(CNT1_LO, 16'h0002);
        wr(STAT_ADDR, 8'h94);
        repeat (30) @(posedge core_clk);
        chk(u_tdc_mem_model.wr_a.size(), 3);
        nmi = 1'b1;
        rdchk(STAT_ADDR, 8'hB4);
        nmi = 1'b0;
        wr(STAT_ADDR, 8'h35);
        rdchk(STAT_ADDR, 8'hB4);
        transfer_request_in_n = 2'h1;
        repeat (30) @(posedge core_clk);
        chk(u_tdc_mem_model.wr_a.size(), 3);
        #2 slow = 1'b1;
        wr(STAT_ADDR, 8'h94);
        bus_wait = 1'b1;
        repeat (5) @(posedge core_clk);
        #2 bus_wait = 1'b0;
        wait_log(5);
        transfer_request_in_n = 2'h3;
        repeat (20) @(posedge core_clk);
        for (int i = 3; i < 5; i++) begin
            chk({u_tdc_mem_model.wr_a[i][19], u_tdc_mem_model.wr_a[i][15:0]}, 17'h1ABCD);
        end
        chk(u_tdc_mem_model.wr_d[3], u_tdc_mem_model.pat(19'h7FFFF));
        chk(u_tdc_mem_model.wr_d[4], u_tdc_mem_model.pat(19'h00000));
        rdchk(STAT_ADDR, 8'h35);
        chk(u_tdc_mem_model.ends, 2);
        // channel 0 cycle steal: source counts down, destination fixed
        wr16(CNT0_LO, 16'h0002);
        wr(MODE_ADDR, 8'h24);
        wr(STAT_ADDR, 8'h64);
        chk(dma_busy, 1'b1);
        wait_log(7);
        for (int i = 5; i < 7; i++) begin
            chk(u_tdc_mem_model.wr_a[i], 20'h30001);
            chk(u_tdc_mem_model.wr_d[i], u_tdc_mem_model.pat(19'h10002 - 19'(i - 5)));
        end
        chk(dma_busy, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
